// ===== hdl/rsvc_pkg.sv
// Package of shared constants and types for the receive signaling and violation counter block.
package rsvc_pkg;

   // ********************************************
   // Sizes
   // ********************************************
   localparam int NUM_PORTS = 8;
   localparam int NUM_CH = 24;
   localparam int CNT_W = 16;
   localparam int SIG_W = 4;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int PORT_W = 3;
   localparam int CH_W = 5;
   localparam int OFS_W = 9;

   // ********************************************
   // Register indices within one port (byte address is four times the index)
   // ********************************************
   localparam logic [OFS_W-1:0] IDX_LCV_HI = 9'h050;
   localparam logic [OFS_W-1:0] IDX_LCV_LO = 9'h051;
   localparam logic [OFS_W-1:0] IDX_PCV_HI = 9'h052;
   localparam logic [OFS_W-1:0] IDX_PCV_LO = 9'h053;
   localparam logic [OFS_W-1:0] IDX_MODE = 9'h0f0;
   localparam logic [OFS_W-1:0] IDX_SIG_BASE = 9'h100;
   localparam logic [CH_W-1:0] CH_LAST = 5'h17;

   // Field positions and reset values.
   localparam int IDX_LSB = 2;
   localparam int PORT_LSB = 11;
   localparam int MODE_ESF_BIT = 0;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [SIG_W-1:0] SIG_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // ********************************************
   // Types
   // ********************************************
   typedef enum logic [2:0] {
      REG_NONE,
      REG_LCV_HI,
      REG_LCV_LO,
      REG_PCV_HI,
      REG_PCV_LO,
      REG_MODE,
      REG_SIG
   } rsvc_reg_e;

   typedef struct packed {
      rsvc_reg_e kind;
      logic [PORT_W-1:0] port;
      logic [CH_W-1:0] chan;
   } rsvc_dec_s;

   // Receive framer report for one port; bits are A, B, C, D from the top.
   typedef struct packed {
      logic line_violation;
      logic path_violation;
      logic sig_valid;
      logic [CH_W-1:0] sig_chan;
      logic [SIG_W-1:0] sig_bits;
      logic framing_lost;
   } rsvc_rx_s;

endpackage : rsvc_pkg

// ===== hdl/rsvc_port.sv
// Per-port violation tallies and receive signaling storage.
`timescale 1ns/1ps
module rsvc_port
   import rsvc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire rsvc_rx_s rx_i,
   input wire logic esf_mode_i,
   input wire logic [CH_W-1:0] rd_chan_i,
   output logic [CNT_W-1:0] line_violation_tally_o,
   output logic [CNT_W-1:0] path_violation_tally_o,
   output logic [SIG_W-1:0] sig_o
);

   logic [CNT_W-1:0] line_violation_tally_r;
   logic [CNT_W-1:0] path_violation_tally_r;
   logic [SIG_W-1:0] sig_mem_r [NUM_CH];
   logic sig_we;
   logic [SIG_W-1:0] sig_nxt;

   // ********************************************
   // Violation tallies
   // ********************************************
   // Tallies stop at all ones rather than wrap, so a host never mistakes a flood for few errors.
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         line_violation_tally_r <= CNT_RESET;
      else if (rx_i.line_violation && line_violation_tally_r != CNT_MAX)
         line_violation_tally_r <= line_violation_tally_r + CNT_ONE;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         path_violation_tally_r <= CNT_RESET;
      else if (rx_i.path_violation && path_violation_tally_r != CNT_MAX)
         path_violation_tally_r <= path_violation_tally_r + CNT_ONE;
   end

   // ********************************************
   // Signaling capture
   // ********************************************
   assign sig_we = rx_i.sig_valid && !rx_i.framing_lost && (rx_i.sig_chan <= CH_LAST);
   assign sig_nxt = esf_mode_i ? rx_i.sig_bits :
                    {rx_i.sig_bits[3:2], rx_i.sig_bits[3:2]};

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         for (int i = 0; i < NUM_CH; i++)
            sig_mem_r[i] <= SIG_RESET;
      end
      else if (sig_we)
         sig_mem_r[rx_i.sig_chan] <= sig_nxt;
   end

   assign line_violation_tally_o = line_violation_tally_r;
   assign path_violation_tally_o = path_violation_tally_r;
   assign sig_o = (rd_chan_i <= CH_LAST) ? sig_mem_r[rd_chan_i] : SIG_RESET;

   // ********************************************
   // Checks
   // ********************************************
   property p_line_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_i.line_violation && line_violation_tally_r != CNT_MAX
      |=> line_violation_tally_r == $past(line_violation_tally_r) + CNT_ONE;
   endproperty
   a_line_step: assert property (p_line_step)
      else $error("Line tally did not step by one.");

   property p_line_hold;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !rx_i.line_violation |=> $stable(line_violation_tally_r);
   endproperty
   a_line_hold: assert property (p_line_hold)
      else $error("Line tally moved without an event.");

   property p_path_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_i.path_violation && path_violation_tally_r != CNT_MAX
      |=> path_violation_tally_r == $past(path_violation_tally_r) + CNT_ONE;
   endproperty
   a_path_step: assert property (p_path_step)
      else $error("Path tally did not step by one.");

   property p_freeze;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_i.framing_lost ##1 $stable(rd_chan_i) |-> $stable(sig_o);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("Signaling changed while framing was lost.");

   property p_d4_copy;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sig_we && !esf_mode_i && rx_i.sig_chan == rd_chan_i ##1 $stable(rd_chan_i)
      |-> sig_o == {$past(rx_i.sig_bits[3:2]), $past(rx_i.sig_bits[3:2])};
   endproperty
   a_d4_copy: assert property (p_d4_copy)
      else $error("D4 signaling not repeated into C and D.");

   property p_esf_capture;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sig_we && esf_mode_i && rx_i.sig_chan == rd_chan_i ##1 $stable(rd_chan_i)
      |-> sig_o == $past(rx_i.sig_bits);
   endproperty
   a_esf_capture: assert property (p_esf_capture)
      else $error("ESF signaling bits not captured.");

endmodule : rsvc_port

// ===== hdl/rsvc_top.sv
// Top level: APB register slave over eight ports of receive signaling and violation tallies.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module rsvc_top
   import rsvc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire rsvc_rx_s [NUM_PORTS-1:0] rx_i
);

   // ********************************************
   // Address decode
   // ********************************************
   function automatic rsvc_dec_s rsvc_decode(input logic [ADDR_W-1:0] a);
      rsvc_dec_s d;
      logic [OFS_W-1:0] ofs;
      logic [OFS_W-1:0] sig_ofs;
      d.port = a[PORT_LSB+:PORT_W];
      d.chan = '0;
      ofs = a[IDX_LSB+:OFS_W];
      sig_ofs = ofs - IDX_SIG_BASE;
      if (a[IDX_LSB-1:0] != '0)
         d.kind = REG_NONE;
      else if (ofs == IDX_LCV_HI)
         d.kind = REG_LCV_HI;
      else if (ofs == IDX_LCV_LO)
         d.kind = REG_LCV_LO;
      else if (ofs == IDX_PCV_HI)
         d.kind = REG_PCV_HI;
      else if (ofs == IDX_PCV_LO)
         d.kind = REG_PCV_LO;
      else if (ofs == IDX_MODE)
         d.kind = REG_MODE;
      else if (ofs >= IDX_SIG_BASE && sig_ofs[CH_W-1:0] <= CH_LAST && sig_ofs[OFS_W-1:CH_W] == '0)
      begin
         d.kind = REG_SIG;
         d.chan = sig_ofs[CH_W-1:0];
      end
      else
         d.kind = REG_NONE;
      return d;
   endfunction : rsvc_decode

   rsvc_dec_s dec;
   logic access_start;
   logic access_done;
   logic [NUM_PORTS-1:0] esf_mode_r;
   logic [DATA_W-1:0] prdata_r;
   logic [DATA_W-1:0] prdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic [CNT_W-1:0] line_tally [NUM_PORTS];
   logic [CNT_W-1:0] path_tally [NUM_PORTS];
   logic [SIG_W-1:0] sig_rd [NUM_PORTS];

   assign dec = rsvc_decode(paddr_i);
   // One wait state: data is gathered in the first access cycle, pready rises in the second.
   assign access_start = psel_i && penable_i && !pready_r;
   assign access_done = psel_i && penable_i && pready_r;

   // ********************************************
   // Ports
   // ********************************************
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_port
      rsvc_port u_port (
         .ref_clk_i(ref_clk_i),
         .reset_n_i(reset_n_i),
         .rx_i(rx_i[p]),
         .esf_mode_i(esf_mode_r[p]),
         .rd_chan_i(dec.chan),
         .line_violation_tally_o(line_tally[p]),
         .path_violation_tally_o(path_tally[p]),
         .sig_o(sig_rd[p])
      );
   end

   // ********************************************
   // Read mux
   // ********************************************
   // Reads only sample the tallies; nothing here feeds back into them.
   always_comb
   begin
      prdata_nxt = DATA_ZERO;
      unique case (dec.kind)
         REG_LCV_HI: prdata_nxt[7:0] = line_tally[dec.port][15:8];
         REG_LCV_LO: prdata_nxt[7:0] = line_tally[dec.port][7:0];
         REG_PCV_HI: prdata_nxt[7:0] = path_tally[dec.port][15:8];
         REG_PCV_LO: prdata_nxt[7:0] = path_tally[dec.port][7:0];
         REG_MODE: prdata_nxt[MODE_ESF_BIT] = esf_mode_r[dec.port];
         REG_SIG: prdata_nxt[SIG_W-1:0] = sig_rd[dec.port];
         REG_NONE: prdata_nxt = DATA_ZERO;
      endcase
   end

   // ********************************************
   // APB handshake
   // ********************************************
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pready_r <= 1'b0;
      else
         pready_r <= access_start;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata_r <= DATA_ZERO;
         pslverr_r <= 1'b0;
      end
      else if (access_start)
      begin
         prdata_r <= pwrite_i ? DATA_ZERO : prdata_nxt;
         pslverr_r <= (dec.kind == REG_NONE);
      end
      else
      begin
         prdata_r <= DATA_ZERO;
         pslverr_r <= 1'b0;
      end
   end

   // The framing mode is the only writable state; tally and signaling writes are dropped.
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         esf_mode_r <= '0;
      else if (access_done && pwrite_i && dec.kind == REG_MODE)
         esf_mode_r[dec.port] <= pwdata_i[MODE_ESF_BIT];
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;

   // ********************************************
   // Checks
   // ********************************************
   property p_line_hi_read;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      access_done && !pwrite_i && dec.kind == REG_LCV_HI
      |-> prdata_r == {24'h000000, $past(line_tally[dec.port][15:8])};
   endproperty
   a_line_hi_read: assert property (p_line_hi_read)
      else $error("Line high byte read mismatch.");

   property p_line_lo_read;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      access_done && !pwrite_i && dec.kind == REG_LCV_LO
      |-> prdata_r == {24'h000000, $past(line_tally[dec.port][7:0])};
   endproperty
   a_line_lo_read: assert property (p_line_lo_read)
      else $error("Line low byte read mismatch.");

   property p_path_hi_read;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      access_done && !pwrite_i && dec.kind == REG_PCV_HI
      |-> prdata_r[7:0] == $past(path_tally[dec.port][15:8]);
   endproperty
   a_path_hi_read: assert property (p_path_hi_read)
      else $error("Path high byte read mismatch.");

   property p_path_lo_read;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      access_done && !pwrite_i && dec.kind == REG_PCV_LO
      |-> prdata_r[7:0] == $past(path_tally[dec.port][7:0]);
   endproperty
   a_path_lo_read: assert property (p_path_lo_read)
      else $error("Path low byte read mismatch.");

   property p_port_stride;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      psel_i |-> dec.port == paddr_i[13:11];
   endproperty
   a_port_stride: assert property (p_port_stride)
      else $error("Port select does not follow the address stride.");

   property p_ready_pulse;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      pready_r |=> !pready_r;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready held longer than one cycle.");

   property p_unmapped_err;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      access_done && dec.kind == REG_NONE |-> pslverr_r && prdata_r == DATA_ZERO;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("Unmapped access not flagged.");

endmodule : rsvc_top

// ===== tb/rsvc_host_model.sv
// Host-side APB master model that reads and writes the per-port status registers.
`timescale 1ns/1ps
module rsvc_host_model
   import rsvc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   input wire logic [DATA_W-1:0] prdata_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [ADDR_W-1:0] paddr_o,
   output logic [DATA_W-1:0] pwdata_o
);
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = DATA_ZERO;
   end

   // ********************************************
   // Transfer
   // ********************************************
   // Signaling is read back right after each update, well inside any polling interval.
   // The request stays put until pready is seen; the bench watchdog ends a hang.
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic err);
      @(posedge ref_clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= addr;
      pwdata_o <= wd;
      @(posedge ref_clk_i);
      penable_o <= 1'b1;
      do @(posedge ref_clk_i); while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask : xfer
endmodule : rsvc_host_model

// ===== tb/tb_top.sv
// Self-checking bench for the receive signaling and violation tally block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("BAD %s exp %h got %h", nm, exp, got); \
      end \
   end
module tb_top
   import rsvc_pkg::*;
();
   logic ref_clk_i = 1'b0;
   logic reset_n_i;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdata;
   rsvc_rx_s [NUM_PORTS-1:0] rx;
   logic [CNT_W-1:0] lcnt [NUM_PORTS];
   logic [CNT_W-1:0] pcnt [NUM_PORTS];
   int n_errors = 0;
   int n_tests = 0;

   always #5 ref_clk_i = ~ref_clk_i;

   rsvc_top u_rsvc_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx));

   rsvc_host_model u_rsvc_host_model (.ref_clk_i(ref_clk_i), .pready_i(pready),
      .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

   // ********************************************
   // Access tasks
   // ********************************************
   function automatic logic [ADDR_W-1:0] reg_addr(input int port, input logic [OFS_W-1:0] idx);
      return ADDR_W'((port * 32'h200 + int'(idx)) << 2);
   endfunction : reg_addr

   task automatic wr(input int port, input logic [OFS_W-1:0] idx, input logic [DATA_W-1:0] d);
      u_rsvc_host_model.xfer(1'b1, reg_addr(port, idx), d, rdata, err);
   endtask : wr

   task automatic chk_reg(input string nm, input int port, input logic [OFS_W-1:0] idx,
      input logic [7:0] exp);
      u_rsvc_host_model.xfer(1'b0, reg_addr(port, idx), DATA_ZERO, rdata, err);
      `CHK(nm, {24'h000000, exp}, rdata)
      `CHK("slave error", 1'b0, err)
   endtask : chk_reg

   task automatic chk_port(input int p, input logic [CNT_W-1:0] lc, input logic [CNT_W-1:0] pc);
      chk_reg("line high", p, IDX_LCV_HI, lc[15:8]);
      chk_reg("line low", p, IDX_LCV_LO, lc[7:0]);
      chk_reg("path high", p, IDX_PCV_HI, pc[15:8]);
      chk_reg("path low", p, IDX_PCV_LO, pc[7:0]);
   endtask : chk_port

   task automatic sig(input int p, input logic [CH_W-1:0] ch, input logic [SIG_W-1:0] bits);
      @(posedge ref_clk_i);
      rx[p].sig_valid <= 1'b1;
      rx[p].sig_chan <= ch;
      rx[p].sig_bits <= bits;
      @(posedge ref_clk_i);
      rx[p].sig_valid <= 1'b0;
   endtask : sig

   task automatic tally_and_finish;
      if (n_errors == 0 && n_tests > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // ********************************************
   // Tests
   // ********************************************
   initial
   begin
      reset_n_i = 1'b0;
      rx = '0;
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         lcnt[p] = 16'h0101 + CNT_W'(p) * 16'h0011;
         pcnt[p] = 16'h0203 - CNT_W'(p);
         chk_port(p, CNT_RESET, CNT_RESET);
      end
      u_rsvc_host_model.xfer(1'b0, reg_addr(1, 9'h054), DATA_ZERO, rdata, err);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", DATA_ZERO, rdata)
      // Distinct counts per port, above 255 so both bytes move.
      for (int i = 0; i < 32'h300; i++)
      begin
         @(posedge ref_clk_i);
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            rx[p].line_violation <= (i < int'(lcnt[p]));
            rx[p].path_violation <= (i < int'(pcnt[p]));
         end
      end
      // The second pass shows that reading leaves the counts alone.
      for (int k = 0; k < 2; k++)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            chk_port(p, lcnt[p], pcnt[p]);
         end
      end
      wr(4, IDX_LCV_LO, 32'h0000_00ff);
      chk_reg("line low after write", 4, IDX_LCV_LO, lcnt[4][7:0]);
      chk_reg("mode", 2, IDX_MODE, 8'h00);
      wr(2, IDX_MODE, 32'h0000_0001);
      sig(2, 5'h05, 4'h5);
      chk_reg("esf signaling", 2, IDX_SIG_BASE + 9'h005, 8'h05);
      // Reading the channel first leaves the decoder pointing at it, so the port checks see the write.
      chk_reg("d4 signaling before", 3, IDX_SIG_BASE + 9'h017, 8'h00);
      sig(3, CH_LAST, 4'h9);
      chk_reg("d4 signaling", 3, IDX_SIG_BASE + 9'h017, 8'h0a);
      chk_reg("esf signaling held", 2, IDX_SIG_BASE + 9'h005, 8'h05);
      @(posedge ref_clk_i);
      rx[2].framing_lost <= 1'b1;
      sig(2, 5'h05, 4'ha);
      chk_reg("frozen signaling", 2, IDX_SIG_BASE + 9'h005, 8'h05);
      rx[2].framing_lost <= 1'b0;
      sig(2, 5'h05, 4'ha);
      chk_reg("resumed signaling", 2, IDX_SIG_BASE + 9'h005, 8'h0a);
      // A second reset in mid-run must bring tallies and mode back to their reset values.
      reset_n_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      chk_port(6, CNT_RESET, CNT_RESET);
      chk_reg("mode after reset", 2, IDX_MODE, 8'h00);
      tally_and_finish();
   end

   initial
   begin
      repeat (10000) @(posedge ref_clk_i);
      n_errors++;
      tally_and_finish();
   end
endmodule : tb_top
